// *** include/ballast_defs.svh ***
// Timing counts for the ballast mode sequencer
`ifndef BALLAST_DEFS_SVH
`define BALLAST_DEFS_SVH
`define CLK_PERIOD_NS 10
// Preheat time in microseconds, default figure of the sequencer
`define PREHEAT_US 1000
`define PREHEAT_CYC ((`PREHEAT_US * 1000) / `CLK_PERIOD_NS)
// Ignition ramp is one quarter of the preheat time
`define IGN_DIVISOR 4
// Switching half period and dead time in nanoseconds
`define HALF_PERIOD_NS 20000
`define HALF_PERIOD_CYC (`HALF_PERIOD_NS / `CLK_PERIOD_NS)
`define DEAD_NS 1000
`define DEAD_CYC ((`DEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** include/ballast_pkg.sv ***
// Types shared by the ballast mode sequencer
package ballast_pkg;
    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_STARTUP = 6'h02,
        ST_PREHEAT = 6'h04,
        ST_IGNITE = 6'h08,
        ST_RUN = 6'h10,
        ST_FAULT = 6'h20
    } mode_t;
    typedef enum logic [2:0] {
        PH_HIGH = 3'h1,
        PH_DEAD = 3'h2,
        PH_LOW = 3'h4
    } phase_t;
endpackage

// *** include/gate_if.sv ***
// Link between the sequencer and its gate driver
`timescale 1ns/100ps
interface gate_if;
    logic run;
    logic topOn;
    logic bottomOn;
    logic bottomFall;
    logic cycleStart;
    modport ctrl (output run, input topOn, bottomOn, bottomFall, cycleStart);
    modport drv (input run, output topOn, bottomOn, bottomFall, cycleStart);
endinterface

// *** hw/gate_driver.sv ***
// Alternating gate driver with dead time between the two switches
`timescale 1ns/100ps
`include "ballast_defs.svh"
module gate_driver
    import ballast_pkg::*;
#(
    parameter int HALF_CYC = `HALF_PERIOD_CYC,
    parameter int DEAD_CYC = `DEAD_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] deadCycles,
    gate_if.drv gi
);
    phase_t phase_reg, phase_next;
    logic nextIsHigh_reg, nextIsHigh_next;
    logic [15:0] count_reg, count_next;
    logic topOn_reg, bottomOn_reg;
    logic lastDone;
    logic [15:0] deadLen;

    assign deadLen = (deadCycles == 16'h0000) ? 16'h0001 : deadCycles;
    assign lastDone = (phase_reg == PH_DEAD) ? (count_reg >= deadLen - 16'h1)
        : (count_reg >= 16'(HALF_CYC - 1));

    // Both gates come from flip-flops; dead phase keeps them apart
    always_comb begin
        phase_next = phase_reg;
        nextIsHigh_next = nextIsHigh_reg;
        count_next = count_reg + 16'h1;
        if (!gi.run) begin
            phase_next = PH_DEAD;
            nextIsHigh_next = 1'b0;
            count_next = 16'h0000;
        end else if (lastDone) begin
            count_next = 16'h0000;
            case (phase_reg)
                PH_DEAD: begin
                    phase_next = nextIsHigh_reg ? PH_HIGH : PH_LOW;
                end
                PH_HIGH: begin
                    phase_next = PH_DEAD;
                    nextIsHigh_next = 1'b0;
                end
                PH_LOW: begin
                    phase_next = PH_DEAD;
                    nextIsHigh_next = 1'b1;
                end
                default: begin
                    phase_next = PH_DEAD;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= PH_DEAD;
            nextIsHigh_reg <= 1'b0;
            count_reg <= 16'h0000;
        end else begin
            phase_reg <= phase_next;
            nextIsHigh_reg <= nextIsHigh_next;
            count_reg <= count_next;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            topOn_reg <= 1'b0;
            bottomOn_reg <= 1'b0;
        end else begin
            topOn_reg <= gi.run && phase_next == PH_HIGH;
            bottomOn_reg <= gi.run && phase_next == PH_LOW;
        end
    end

    assign gi.topOn = topOn_reg;
    assign gi.bottomOn = bottomOn_reg;
    assign gi.bottomFall = bottomOn_reg && phase_next != PH_LOW;
    assign gi.cycleStart = gi.run && phase_reg == PH_DEAD && lastDone
        && nextIsHigh_reg;
endmodule // gate_driver

// *** hw/ballast_mode_sequencer.sv ***
// Mode sequencer and fault protection of a half-bridge lamp ballast
`timescale 1ns/100ps
`include "ballast_defs.svh"
// Behaviour
// - Start only with supply, bus and lamp good
// - Low bus stops the oscillator
// - After low bus, restart from startup
// - Lamp detect high: stop, gates low, unlatched
// - Lamp detect low again: internal reset, restart
// - Current fault: latch, stop, gates low
// - Current checked every switching cycle
// - Overcurrent armed only after preheat ends
// - Undercurrent armed only from run mode
// - Undercurrent sampled at bottom gate falling
// - Lamp detect high clears fault latch
// - Supply undervoltage also clears fault latch
// - Preheat end releases heat frequency node
// - Ramp end turns on run switch
// - Ignition ramp lasts quarter of preheat
// - Overtemperature latches off; same clearing
module ballast_mode_sequencer
    import ballast_pkg::*;
#(
    parameter int PREHEAT_CYC = `PREHEAT_CYC,
    parameter int STARTUP_CYC = 16,
    parameter int HALF_CYC = `HALF_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic supplyOk,
    input wire logic busAboveUpper,
    input wire logic busAboveLower,
    input wire logic lampDetectHigh,
    input wire logic lampDetectLow,
    input wire logic overCurrent,
    input wire logic underCurrent,
    input wire logic overTemp,
    input wire logic [15:0] deadCycles,
    output logic top_switch_gate,
    output logic bottom_switch_gate,
    output logic heatFreqHoldLow,
    output logic runSwitchOn,
    output logic ramp_cap_node_enable,
    output logic faultLatched,
    output logic microPower,
    output logic [5:0] modeState
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int IGN_CYC = PREHEAT_CYC / `IGN_DIVISOR;
    mode_t mode_reg, mode_next;
    logic [31:0] timer_reg, timer_next;
    logic fault_reg, fault_next;
    logic lampOff_reg, lampOff_next;
    logic startOk, faultClear, ocTrip, ucTrip, anyFault, timerDone;
    logic stopNow;
    gate_if gi();

    gate_driver #(
        .HALF_CYC(HALF_CYC),
        .DEAD_CYC(`DEAD_CYC)
    ) u_gate (
        .clk(clk),
        .nrst(nrst),
        .deadCycles(deadCycles),
        .gi(gi)
    );

    // ------------------------------------------------------------
    // Condition decode
    // ------------------------------------------------------------
    assign startOk = supplyOk && busAboveUpper && lampDetectLow;
    // Clearing beats any fault arriving the same cycle; lamp removal is
    // a user action, so it wins
    assign faultClear = lampDetectHigh || !supplyOk;
    // Armed overcurrent is taken each clock, undercurrent only at bottom gate falling; no averaging
    assign ocTrip = overCurrent && (mode_reg == ST_IGNITE
        || mode_reg == ST_RUN);
    assign ucTrip = underCurrent && mode_reg == ST_RUN
        && gi.bottomFall;
    assign anyFault = ocTrip || ucTrip || overTemp;
    assign stopNow = !supplyOk || !busAboveLower || lampDetectHigh;
    assign timerDone = (mode_reg == ST_STARTUP
        && timer_reg >= 32'(STARTUP_CYC - 1))
        || (mode_reg == ST_PREHEAT
        && timer_reg >= 32'(PREHEAT_CYC - 1))
        || (mode_reg == ST_IGNITE
        && timer_reg >= 32'(IGN_CYC - 1));

    // ------------------------------------------------------------
    // Mode sequence
    // ------------------------------------------------------------
    always_comb begin
        mode_next = mode_reg;
        timer_next = timer_reg + 32'h1;
        fault_next = fault_reg;
        lampOff_next = lampOff_reg;
        if (lampDetectHigh) begin
            lampOff_next = 1'b1;
        end else if (lampDetectLow) begin
            lampOff_next = 1'b0;
        end
        if (faultClear) begin
            fault_next = 1'b0;
        end else if (anyFault) begin
            fault_next = 1'b1;
        end
        if (stopNow) begin
            // Always back to off so restart begins at startup
            mode_next = ST_OFF;
            timer_next = 32'h0;
        end else if (fault_next) begin
            // One cycle in fault, then parked in off until the latch clears
            mode_next = (mode_reg == ST_FAULT || mode_reg == ST_OFF)
                ? ST_OFF : ST_FAULT;
            timer_next = 32'h0;
        end else begin
            case (mode_reg)
                ST_OFF: begin
                    timer_next = 32'h0;
                    if (startOk) begin
                        mode_next = ST_STARTUP;
                    end
                end
                ST_STARTUP: begin
                    if (timerDone) begin
                        mode_next = ST_PREHEAT;
                        timer_next = 32'h0;
                    end
                end
                ST_PREHEAT: begin
                    if (timerDone) begin
                        mode_next = ST_IGNITE;
                        timer_next = 32'h0;
                    end
                end
                ST_IGNITE: begin
                    if (timerDone) begin
                        mode_next = ST_RUN;
                        timer_next = 32'h0;
                    end
                end
                ST_RUN: begin
                    timer_next = 32'h0;
                end
                ST_FAULT: begin
                    timer_next = 32'h0;
                    mode_next = ST_OFF;
                end
                default: begin
                    mode_next = ST_OFF;
                    timer_next = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= ST_OFF;
            timer_reg <= 32'h0;
            fault_reg <= 1'b0;
            lampOff_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            timer_reg <= timer_next;
            fault_reg <= fault_next;
            lampOff_reg <= lampOff_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Oscillator runs only in active modes; gates fall one clock after it
    assign gi.run = mode_reg == ST_STARTUP || mode_reg == ST_PREHEAT
        || mode_reg == ST_IGNITE || mode_reg == ST_RUN;
    assign top_switch_gate = gi.topOn;
    assign bottom_switch_gate = gi.bottomOn;
    assign ramp_cap_node_enable = gi.run;
    assign heatFreqHoldLow = mode_reg == ST_STARTUP
        || mode_reg == ST_PREHEAT;
    assign runSwitchOn = mode_reg == ST_RUN;
    assign faultLatched = fault_reg;
    assign microPower = fault_reg || lampOff_reg;
    assign modeState = mode_reg;
endmodule // ballast_mode_sequencer

// *** verification/ballast_mode_sequencer_props.sv ***
// Port-level assertions for the ballast mode sequencer
`timescale 1ns/100ps
module ballast_mode_sequencer_props
    import ballast_pkg::*;
#(
    parameter int PREHEAT_CYC = 40
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic supplyOk,
    input wire logic busAboveUpper,
    input wire logic busAboveLower,
    input wire logic lampDetectHigh,
    input wire logic lampDetectLow,
    input wire logic overCurrent,
    input wire logic underCurrent,
    input wire logic overTemp,
    input wire logic [15:0] deadCycles,
    input wire logic top_switch_gate,
    input wire logic bottom_switch_gate,
    input wire logic heatFreqHoldLow,
    input wire logic runSwitchOn,
    input wire logic ramp_cap_node_enable,
    input wire logic faultLatched,
    input wire logic microPower,
    input wire logic [5:0] modeState
);
    // ------------------------------------------
    // Cycles spent in the current mode
    // ------------------------------------------
    logic [5:0] prevMode_reg;
    logic [31:0] modeCnt_reg;
    logic [31:0] modeCnt_next;
    assign modeCnt_next = (modeState != prevMode_reg) ? 32'h1
        : modeCnt_reg + 32'h1;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prevMode_reg <= 6'h01;
            modeCnt_reg <= 32'h0;
        end else begin
            prevMode_reg <= modeState;
            modeCnt_reg <= modeCnt_next;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence enterIgnite;
        modeState == ST_IGNITE && prevMode_reg == ST_PREHEAT;
    endsequence
    sequence enterRun;
        modeState == ST_RUN && prevMode_reg == ST_IGNITE;
    endsequence
    sequence offThenLeave;
        modeState == ST_OFF ##1 modeState != ST_OFF;
    endsequence
    a_gates_apart: assert property (
        !(top_switch_gate && bottom_switch_gate)) else $error("gate overlap");
    a_start_refused: assert property (
        modeState == ST_OFF && !(supplyOk && busAboveUpper && lampDetectLow)
        |=> modeState != ST_STARTUP) else $error("start while not ok");
    a_low_bus_stop: assert property (
        modeState inside {ST_PREHEAT, ST_IGNITE, ST_RUN} && !busAboveLower
        |-> ##[1:2] !ramp_cap_node_enable) else $error("bus low kept on");
    a_lamp_off_quiet: assert property (
        lampDetectHigh [*3] |-> !top_switch_gate && !bottom_switch_gate
        && microPower && !faultLatched) else $error("lamp off not quiet");
    a_fault_taken: assert property (
        modeState == ST_RUN && overCurrent && supplyOk && !lampDetectHigh
        |=> faultLatched && microPower ##1 !top_switch_gate
        && !bottom_switch_gate) else $error("fault not taken");
    a_early_unarmed: assert property (
        modeState inside {ST_STARTUP, ST_PREHEAT, ST_IGNITE} && !overTemp
        && !faultLatched && !(modeState == ST_IGNITE && overCurrent)
        |=> !faultLatched) else $error("fault while unarmed");
    a_preheat_len: assert property (
        enterIgnite |-> modeCnt_reg == PREHEAT_CYC && !heatFreqHoldLow
        && !runSwitchOn) else $error("preheat length wrong");
    a_ramp_len: assert property (
        enterRun |-> modeCnt_reg == PREHEAT_CYC / 4 && runSwitchOn)
        else $error("ramp length wrong");
    a_restart_first: assert property (
        offThenLeave |-> modeState == ST_STARTUP) else $error("bad restart");
endmodule // ballast_mode_sequencer_props

// *** verification/lamp_model.sv ***
// Half-bridge and lamp stand-in turning gate drive into current flags
`timescale 1ns/100ps
module lamp_model (
    input wire logic bottomGate,
    input wire logic noStrike,
    input wire logic lowLoad,
    output logic overCurrent,
    output logic underCurrent
);
    // Surge current only flows while the bottom switch conducts
    assign overCurrent = noStrike & bottomGate;
    assign underCurrent = lowLoad;
endmodule // lamp_model

// *** verification/tb_top.sv ***
// Self-checking bench for the ballast mode sequencer
`timescale 1ns/100ps
module tb_top;
    import ballast_pkg::*;
    logic clk, nrst, supplyOk, busAboveUpper, busAboveLower;
    logic lampDetectHigh, lampDetectLow, overCurrent, underCurrent;
    logic overTemp, noStrike, lowLoad, top_switch_gate, bottom_switch_gate;
    logic heatFreqHoldLow, runSwitchOn, ramp_cap_node_enable;
    logic faultLatched, microPower;
    logic [15:0] deadCycles = 16'h0003;
    logic [5:0] modeState;
    logic [5:0] lastMode = 6'h01;
    logic [5:0] expQ[$];
    logic [31:0] seed = 32'h4368;
    int n_mismatch = 0;
    int compares = 0;
    ballast_mode_sequencer #(.PREHEAT_CYC(40), .HALF_CYC(8)) dut_u (
        .clk, .nrst, .supplyOk, .busAboveUpper, .busAboveLower,
        .lampDetectHigh, .lampDetectLow, .overCurrent, .underCurrent,
        .overTemp, .deadCycles, .top_switch_gate, .bottom_switch_gate,
        .heatFreqHoldLow, .runSwitchOn, .ramp_cap_node_enable,
        .faultLatched, .microPower, .modeState);
    lamp_model partner_u (.bottomGate(bottom_switch_gate), .noStrike,
        .lowLoad, .overCurrent, .underCurrent);
    // ------------------------------------------
    // Helpers
    // ------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check_mode(input logic [5:0] got, input logic [5:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_mode({5'h00, got}, {5'h00, exp});
    endtask
    task automatic go(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_mode(input logic [5:0] m);
        for (int i = 0; i < 300 && modeState !== m; i++) go(1);
        check_mode(modeState, m);
    endtask
    task automatic push_run;
        expQ = {expQ, ST_STARTUP, ST_PREHEAT, ST_IGNITE, ST_RUN};
    endtask
    task automatic relamp;
        lampDetectHigh = 1;
        lampDetectLow = 0;
        go(5);
        check_bit(faultLatched, 1'b0);
        check_bit(microPower, 1'b1);
        push_run;
        lampDetectHigh = 0;
        lampDetectLow = 1;
        wait_mode(ST_RUN);
        check_bit(runSwitchOn, 1'b1);
        check_bit(heatFreqHoldLow, 1'b0);
        check_bit(microPower, 1'b0);
    endtask
    task automatic print_verdict;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ------------------------------------------
    // Clock, watchdog and mode monitor
    // ------------------------------------------
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        n_mismatch++;
        print_verdict;
    end
    // Every mode change must match the oldest expected note
    initial forever begin
        @(posedge clk);
        #1;
        if (nrst && modeState !== lastMode) begin
            if (expQ.size() == 0) check_mode(modeState, 6'h3f);
            else check_mode(modeState, expQ.pop_front());
        end
        lastMode = modeState;
    end
    initial begin
        nrst = 0;
        supplyOk = 1;
        busAboveUpper = 0;
        busAboveLower = 1;
        lampDetectHigh = 0;
        lampDetectLow = 1;
        overTemp = 0;
        noStrike = 0;
        lowLoad = 0;
        go(20);
        nrst = 1;
        go(10);
        push_run;
        busAboveUpper = 1;
        wait_mode(ST_PREHEAT);
        noStrike = 1;
        repeat (30) begin
            lowLoad = seed[0];
            seed = xs(seed);
            go(1);
        end
        noStrike = 0;
        wait_mode(ST_IGNITE);
        lowLoad = 1;
        wait_mode(ST_RUN);
        lowLoad = 0;
        for (int i = 0; i < 40 && bottom_switch_gate !== 1'b1; i++) go(1);
        lowLoad = 1;
        go(3);
        lowLoad = 0;
        go(1 + seed[4:0]);
        check_bit(faultLatched, 1'b0);
        expQ = {expQ, ST_FAULT, ST_OFF};
        noStrike = 1;
        wait_mode(ST_OFF);
        noStrike = 0;
        check_bit(faultLatched, 1'b1);
        check_bit(top_switch_gate | bottom_switch_gate, 1'b0);
        go(30);
        relamp;
        expQ.push_back(ST_OFF);
        busAboveLower = 0;
        busAboveUpper = 0;
        go(3);
        check_bit(ramp_cap_node_enable, 1'b0);
        push_run;
        busAboveLower = 1;
        busAboveUpper = 1;
        wait_mode(ST_RUN);
        expQ.push_back(ST_OFF);
        relamp;
        expQ = {expQ, ST_FAULT, ST_OFF};
        lowLoad = 1;
        wait_mode(ST_OFF);
        lowLoad = 0;
        supplyOk = 0;
        go(2);
        check_bit(faultLatched, 1'b0);
        push_run;
        supplyOk = 1;
        wait_mode(ST_RUN);
        expQ = {expQ, ST_FAULT, ST_OFF};
        overTemp = 1;
        go(1);
        overTemp = 0;
        wait_mode(ST_OFF);
        check_bit(faultLatched, 1'b1);
        relamp;
        print_verdict;
    end
endmodule // tb_top
bind ballast_mode_sequencer ballast_mode_sequencer_props #(
    .PREHEAT_CYC(PREHEAT_CYC)) props_u (.*);
